//--- rtl/lpc_lane_dev.sv
// Purpose: Lane device end: clock lane transmit power states, data lane
//          receive power states and their status lines
// Assumes: Protocol end shares i_clk; data lane line levels arrive from pins
// Notes:   Status outputs are gated by the enables without any clock, so
//          they change as soon as a lane is switched off
`timescale 1ns/1ps

module lpc_lane_dev #(
  parameter int WAKE_CYC = lpc_pkg::WAKE_CYC
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  // Clock lane line drive
  output logic      [1:0]                 o_cl_line,
  output logic                            o_cl_line_oe,
  output logic                            o_cl_hs_clk_on,
  // Data lane line sense, {p, n} per lane
  input  wire logic [1:0]                 i_dl_line [lpc_pkg::NUM_DL],
  output logic      [lpc_pkg::NUM_DL-1:0] o_dl_rx_on,
  // Lane interface
  lpc_ppi_if.dev                          ppi
);

  localparam int                      N         = lpc_pkg::NUM_DL;
  localparam int                      CW        = lpc_pkg::CNT_W;
  localparam logic [lpc_pkg::CNT_W-1:0] WAKE_LAST = CW'(WAKE_CYC - 1);

  typedef struct packed {
    lpc_pkg::lpc_cl_e                cl;
    lpc_pkg::lpc_dl_e [N-1:0]        dl;
    logic [N-1:0][CW-1:0]            wcnt;
    logic [N-1:0][1:0]               s1;
    logic [N-1:0][1:0]               s2;
    logic [N-1:0][1:0]               s3;
    logic [N-1:0][1:0]               lvl;
    logic [1:0]                      cl_line;
    logic                            cl_oe;
    logic                            cl_hs;
  } lpc_dev_s;

  lpc_dev_s q;
  lpc_dev_s d;

  always_comb begin
    d = q;

    // Clock lane transmit sequencing
    if (!ppi.clock_lane_on) begin
      d.cl = lpc_pkg::CL_OFF;
    end else begin
      case (q.cl)
        lpc_pkg::CL_OFF: begin
          d.cl = lpc_pkg::CL_STOP;
        end
        lpc_pkg::CL_STOP: begin
          if (ppi.clock_lane_fast_request) begin
            d.cl = lpc_pkg::CL_HS;
          end else if (ppi.clock_lane_low_power_request) begin
            d.cl = lpc_pkg::CL_ULPS;
          end
        end
        lpc_pkg::CL_HS: begin
          if (!ppi.clock_lane_fast_request) begin
            d.cl = lpc_pkg::CL_STOP;
          end
        end
        lpc_pkg::CL_ULPS: begin
          if (ppi.low_power_exit_request || !ppi.clock_lane_low_power_request) begin
            d.cl = lpc_pkg::CL_MARK;
          end
        end
        lpc_pkg::CL_MARK: begin
          if (!ppi.clock_lane_low_power_request) begin
            d.cl = lpc_pkg::CL_STOP;
          end
        end
        default: begin
          d.cl = lpc_pkg::CL_OFF;
        end
      endcase
    end
    // Exit only read in ULP state above

    // Clock lane line levels follow the next state
    d.cl_oe   = 1'b1;
    d.cl_hs   = 1'b0;
    d.cl_line = lpc_pkg::LP11;
    case (d.cl)
      lpc_pkg::CL_ULPS: d.cl_line = lpc_pkg::LP00;
      lpc_pkg::CL_MARK: d.cl_line = lpc_pkg::LP10;
      lpc_pkg::CL_HS: begin
        d.cl_oe = 1'b0;
        d.cl_hs = 1'b1;
      end
      lpc_pkg::CL_OFF: d.cl_oe = 1'b0;
      default: d.cl_line = lpc_pkg::LP11;
    endcase

    for (int i = 0; i < N; i++) begin
      // Pin levels: first stage feeds only the second
      d.s1[i] = i_dl_line[i];
      d.s2[i] = q.s1[i];
      d.s3[i] = q.s2[i];
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end

      if (!ppi.data_lane_on[i]) begin
        d.dl[i]   = lpc_pkg::DL_OFF;
        d.wcnt[i] = '0;
      end else begin
        case (q.dl[i])
          lpc_pkg::DL_OFF: begin
            d.dl[i] = (q.lvl[i] == lpc_pkg::LP11) ? lpc_pkg::DL_STOP : lpc_pkg::DL_LP;
          end
          lpc_pkg::DL_STOP: begin
            if (q.lvl[i] == lpc_pkg::LP00) begin
              d.dl[i] = lpc_pkg::DL_ULPS;
            end else if (q.lvl[i] != lpc_pkg::LP11) begin
              d.dl[i] = lpc_pkg::DL_LP;
            end
          end
          lpc_pkg::DL_ULPS: begin
            if (q.lvl[i] == lpc_pkg::LP10) begin
              d.dl[i]   = lpc_pkg::DL_WAKE;
              d.wcnt[i] = '0;
            end
          end
          lpc_pkg::DL_WAKE: begin
            d.wcnt[i] = q.wcnt[i] + CW'(1);
            if (q.wcnt[i] == WAKE_LAST) begin
              d.dl[i]   = lpc_pkg::DL_LP;
              d.wcnt[i] = '0;
            end
          end
          lpc_pkg::DL_LP: begin
            if (q.lvl[i] == lpc_pkg::LP11) begin
              d.dl[i] = lpc_pkg::DL_STOP;
            end
          end
          default: begin
            d.dl[i] = lpc_pkg::DL_OFF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q         <= '0;
      q.cl_line <= lpc_pkg::LP11;
      // Pins idle at Stop; avoids a false level right after reset
      q.s1      <= {N{lpc_pkg::LP11}};
      q.s2      <= {N{lpc_pkg::LP11}};
      q.s3      <= {N{lpc_pkg::LP11}};
      q.lvl     <= {N{lpc_pkg::LP11}};
    end else if (i_ce) begin
      q <= d;
    end
  end

  // Clock lane outputs; enable gates all but o_cl_line with no clock involved
  always_comb begin
    o_cl_line_oe   = q.cl_oe & ppi.clock_lane_on;
    o_cl_hs_clk_on = q.cl_hs & ppi.clock_lane_on;
    o_cl_line      = q.cl_line;
    ppi.clock_lane_stop_flag          = ppi.clock_lane_on & (q.cl == lpc_pkg::CL_STOP);
    ppi.clock_lane_low_power_active_n = ~(ppi.clock_lane_on & (q.cl == lpc_pkg::CL_ULPS));
  end

  // Data lane status; a lane off shows the inactive defaults
  always_comb begin
    for (int i = 0; i < N; i++) begin
      o_dl_rx_on[i] = ppi.data_lane_on[i];
      ppi.data_lane_stop_flag[i]          = ppi.data_lane_on[i] & (q.dl[i] == lpc_pkg::DL_STOP);
      ppi.data_lane_low_power_active_n[i] = ~(ppi.data_lane_on[i] & (q.dl[i] == lpc_pkg::DL_ULPS));
      ppi.data_lane_rx_low_power_flag[i]  = ppi.data_lane_on[i]
                                            & ((q.dl[i] == lpc_pkg::DL_ULPS) | (q.dl[i] == lpc_pkg::DL_WAKE));
    end
  end

endmodule : lpc_lane_dev

//--- rtl/lpc_pkg.sv
// Purpose: Shared constants and state codes for the lane power control ends
// Assumes: One 10 MHz clock for every lane function
// Notes:   Line levels are {p, n}; Mark-1 is p high, n low
package lpc_pkg;

  // Lane counts
  localparam int NUM_DL = 4;

  // Line levels {p, n}
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP00 = 2'h0;

  // Timing
  localparam int CLK_NS     = 100;
  localparam int TWAKEUP_NS = 1000000;
  localparam int WAKE_CYC   = (TWAKEUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 14;

  // Status vector seen by the protocol end
  localparam int          STAT_W   = 14;
  localparam int          ST_CSTOP = 13;
  localparam int          ST_DSTOP = 9;
  localparam int          ST_CACT  = 8;
  localparam int          ST_DACT  = 4;
  localparam int          ST_DFLAG = 0;
  localparam logic [13:0] STAT_RST = 14'h01F0;

  // Clock lane transmit states
  typedef enum logic [2:0] {
    CL_OFF  = 3'h0,
    CL_STOP = 3'h1,
    CL_HS   = 3'h2,
    CL_ULPS = 3'h3,
    CL_MARK = 3'h4
  } lpc_cl_e;

  // Data lane receive states
  typedef enum logic [2:0] {
    DL_OFF  = 3'h0,
    DL_STOP = 3'h1,
    DL_ULPS = 3'h2,
    DL_WAKE = 3'h3,
    DL_LP   = 3'h4
  } lpc_dl_e;

endpackage : lpc_pkg

//--- rtl/lpc_ppi_if.sv
// Purpose: Lane control signals between protocol logic and lane device
// Assumes: Both ends share i_clk
// Notes:   Status lines count as asynchronous at the protocol end
`timescale 1ns/1ps
interface lpc_ppi_if;
  // Controls from the protocol end
  logic                        clock_lane_on;
  logic [lpc_pkg::NUM_DL-1:0]  data_lane_on;
  logic                        clock_lane_fast_request;
  logic                        clock_lane_low_power_request;
  logic                        low_power_exit_request;
  // Status from the device end
  logic                        clock_lane_stop_flag;
  logic [lpc_pkg::NUM_DL-1:0]  data_lane_stop_flag;
  logic                        clock_lane_low_power_active_n;
  logic [lpc_pkg::NUM_DL-1:0]  data_lane_low_power_active_n;
  logic [lpc_pkg::NUM_DL-1:0]  data_lane_rx_low_power_flag;

  modport dev (
    input  clock_lane_on, data_lane_on, clock_lane_fast_request,
           clock_lane_low_power_request, low_power_exit_request,
    output clock_lane_stop_flag, data_lane_stop_flag, clock_lane_low_power_active_n,
           data_lane_low_power_active_n, data_lane_rx_low_power_flag
  );

  modport prot (
    output clock_lane_on, data_lane_on, clock_lane_fast_request,
           clock_lane_low_power_request, low_power_exit_request,
    input  clock_lane_stop_flag, data_lane_stop_flag, clock_lane_low_power_active_n,
           data_lane_low_power_active_n, data_lane_rx_low_power_flag
  );
endinterface : lpc_ppi_if

//--- rtl/lpc_lane_prot.sv
// Purpose: Protocol-side end driving lane enables and power requests
// Assumes: Device status lines may change at any time
// Notes:   Exit request is only passed while the clock lane reports low power
`timescale 1ns/1ps
module lpc_lane_prot (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_ce,
  // User requests
  input  wire logic                       i_cl_on,
  input  wire logic [lpc_pkg::NUM_DL-1:0] i_dl_on,
  input  wire logic                       i_fast_req,
  input  wire logic                       i_low_power_req,
  input  wire logic                       i_exit_req,
  // Synchronised status
  output logic                            o_cl_stop,
  output logic      [lpc_pkg::NUM_DL-1:0] o_dl_stop,
  output logic                            o_cl_low_power_active_n,
  output logic      [lpc_pkg::NUM_DL-1:0] o_dl_low_power_active_n,
  output logic      [lpc_pkg::NUM_DL-1:0] o_dl_rx_low_power_flag,
  // Lane interface
  lpc_ppi_if.prot                         ppi
);

  typedef struct packed {
    logic [lpc_pkg::STAT_W-1:0] s1;
    logic [lpc_pkg::STAT_W-1:0] s2;
    logic [lpc_pkg::STAT_W-1:0] s3;
    logic [lpc_pkg::STAT_W-1:0] stat;
    logic                       cl_on;
    logic [lpc_pkg::NUM_DL-1:0] dl_on;
    logic                       fast;
    logic                       lp;
    logic                       exit;
  } lpc_prot_s;

  lpc_prot_s q;
  lpc_prot_s d;
  logic [lpc_pkg::STAT_W-1:0] raw;

  assign raw = {ppi.clock_lane_stop_flag, ppi.data_lane_stop_flag, ppi.clock_lane_low_power_active_n,
                ppi.data_lane_low_power_active_n, ppi.data_lane_rx_low_power_flag};

  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int b = 0; b < lpc_pkg::STAT_W; b++) begin
      if (q.s2[b] == q.s3[b]) begin
        d.stat[b] = q.s3[b];
      end
    end
    d.cl_on = i_cl_on;
    d.dl_on = i_dl_on;
    d.fast  = i_fast_req;
    d.lp    = i_low_power_req;
    d.exit  = i_exit_req & ~q.stat[lpc_pkg::ST_CACT];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q      <= '0;
      q.s1   <= lpc_pkg::STAT_RST;
      q.s2   <= lpc_pkg::STAT_RST;
      q.s3   <= lpc_pkg::STAT_RST;
      q.stat <= lpc_pkg::STAT_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign ppi.clock_lane_on                = q.cl_on;
  assign ppi.data_lane_on                 = q.dl_on;
  assign ppi.clock_lane_fast_request      = q.fast;
  assign ppi.clock_lane_low_power_request = q.lp;
  assign ppi.low_power_exit_request       = q.exit;

  assign o_cl_stop               = q.stat[lpc_pkg::ST_CSTOP];
  assign o_dl_stop               = q.stat[lpc_pkg::ST_DSTOP +: lpc_pkg::NUM_DL];
  assign o_cl_low_power_active_n = q.stat[lpc_pkg::ST_CACT];
  assign o_dl_low_power_active_n = q.stat[lpc_pkg::ST_DACT +: lpc_pkg::NUM_DL];
  assign o_dl_rx_low_power_flag  = q.stat[lpc_pkg::ST_DFLAG +: lpc_pkg::NUM_DL];

endmodule : lpc_lane_prot

//--- dv/lpc_ppi_asserts.sv
// Purpose: Interface assertions for the two lane power control ends
// Assumes: i_ce held high on both ends; one clock
// Notes:   Status lines are combinational, judged at i_clk edges
`timescale 1ns/1ps
module lpc_ppi_asserts #(
  parameter int WAKE_CYC = 8
) (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  // Controls
  input wire logic       clock_lane_on,
  input wire logic [3:0] data_lane_on,
  input wire logic       clock_lane_fast_request,
  input wire logic       clock_lane_low_power_request,
  input wire logic       low_power_exit_request,
  // Status
  input wire logic       clock_lane_stop_flag,
  input wire logic [3:0] data_lane_stop_flag,
  input wire logic       clock_lane_low_power_active_n,
  input wire logic [3:0] data_lane_low_power_active_n,
  input wire logic [3:0] data_lane_rx_low_power_flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Cycles lane 0 spends waking
  logic [13:0] wake_q;
  logic        waking;
  assign waking = data_lane_on[0] && data_lane_low_power_active_n[0] && data_lane_rx_low_power_flag[0];
  always_ff @(posedge i_clk) begin
    wake_q <= (!i_rst_n || !waking) ? 14'h0 : wake_q + 14'h1;
  end

  chk_cl_off_quiet: assert property (
    !clock_lane_on |-> !clock_lane_stop_flag && clock_lane_low_power_active_n)
    else $error("clock lane status active while off");
  chk_dl_off_quiet: assert property (
    ((data_lane_stop_flag | data_lane_rx_low_power_flag | ~data_lane_low_power_active_n) & ~data_lane_on) == 4'h0)
    else $error("data lane status active while off");
  chk_clock_lane_on_stop: assert property (
    clock_lane_on && !$past(clock_lane_on) |=> clock_lane_stop_flag)
    else $error("clock lane missed stop after enable");
  chk_fast_leaves_stop: assert property (
    clock_lane_on && clock_lane_stop_flag && clock_lane_fast_request |=> !clock_lane_stop_flag)
    else $error("fast request did not leave stop");
  chk_ulps_entry_hold: assert property (
    clock_lane_on && clock_lane_low_power_request && !clock_lane_fast_request
    && !low_power_exit_request && (clock_lane_stop_flag || !clock_lane_low_power_active_n)
    |=> !clock_lane_low_power_active_n)
    else $error("clock lane not held in low power");
  chk_exit_to_mark: assert property (
    clock_lane_on && !clock_lane_low_power_active_n && low_power_exit_request
    |=> clock_lane_low_power_active_n && !clock_lane_stop_flag)
    else $error("exit request did not give mark");
  chk_mark_to_stop: assert property (
    clock_lane_on && $rose(clock_lane_low_power_active_n) && !clock_lane_low_power_request
    |=> clock_lane_stop_flag)
    else $error("mark did not return to stop");
  chk_exit_ignored: assert property (
    clock_lane_on && clock_lane_stop_flag && low_power_exit_request
    && !clock_lane_low_power_request && !clock_lane_fast_request |=> clock_lane_stop_flag)
    else $error("exit request acted outside low power");
  chk_dl_flag_with: assert property (
    (~data_lane_low_power_active_n & ~data_lane_rx_low_power_flag) == 4'h0)
    else $error("low power indication without flag");
  chk_dl_wake_len: assert property (
    $fell(data_lane_rx_low_power_flag[0]) && data_lane_on[0] |-> wake_q >= WAKE_CYC && wake_q <= WAKE_CYC + 1)
    else $error("wakeup period wrong length");

  cov_fast: cover property (clock_lane_stop_flag ##1 clock_lane_fast_request && !clock_lane_stop_flag);
  cov_exit_ignored: cover property (clock_lane_stop_flag && low_power_exit_request);
  cov_wake: cover property ($fell(data_lane_rx_low_power_flag[0]) && data_lane_on[0]);
  cov_ulps_exit: cover property (clock_lane_on && $rose(clock_lane_low_power_active_n));
endmodule : lpc_ppi_asserts

//--- dv/tb_top.sv
// Purpose: Joins both lane ends and walks clock and data lane power states
// Assumes: Short wakeup count; status noted in a queue, checked on change
// Notes:   Synced status word compared at every change, so stray changes fail
`timescale 1ns/1ps
module tb_top;
  localparam int WAKE = 8;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cl_on = 1'b0;
  logic        fast = 1'b0;
  logic        lp = 1'b0;
  logic        ex = 1'b0;
  logic [3:0]  dl_on = 4'h0;
  logic [1:0]  dl_line [lpc_pkg::NUM_DL];
  logic        cl_stop;
  logic        cl_act_n;
  logic [3:0]  dl_stop;
  logic [3:0]  dl_act_n;
  logic [3:0]  dl_flag;
  logic [3:0]  rx_on;
  logic [1:0]  cl_line;
  logic        cl_oe;
  logic        hs_on;
  logic [13:0] word;
  logic [13:0] prev_q = lpc_pkg::STAT_RST;
  logic [13:0] exp_q [$];
  logic [3:0]  m;
  int          fails = 0;
  int          cmp_count = 0;
  integer      seed = 32'h5BA1E4F5;

  always #50 i_clk = ~i_clk;
  assign word = {cl_stop, dl_stop, cl_act_n, dl_act_n, dl_flag};

  lpc_ppi_if i_lpc_ppi_if ();
  lpc_lane_prot i_lpc_lane_prot (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cl_on(cl_on),
    .i_dl_on(dl_on), .i_fast_req(fast), .i_low_power_req(lp), .i_exit_req(ex), .o_cl_stop(cl_stop),
    .o_dl_stop(dl_stop), .o_cl_low_power_active_n(cl_act_n), .o_dl_low_power_active_n(dl_act_n),
    .o_dl_rx_low_power_flag(dl_flag), .ppi(i_lpc_ppi_if));
  lpc_lane_dev #(.WAKE_CYC(WAKE)) i_lpc_lane_dev (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .o_cl_line(cl_line), .o_cl_line_oe(cl_oe), .o_cl_hs_clk_on(hs_on), .i_dl_line(dl_line),
    .o_dl_rx_on(rx_on), .ppi(i_lpc_ppi_if));
  lpc_ppi_asserts #(.WAKE_CYC(WAKE)) i_lpc_ppi_asserts (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .clock_lane_on(i_lpc_ppi_if.clock_lane_on), .data_lane_on(i_lpc_ppi_if.data_lane_on),
    .clock_lane_fast_request(i_lpc_ppi_if.clock_lane_fast_request),
    .clock_lane_low_power_request(i_lpc_ppi_if.clock_lane_low_power_request),
    .low_power_exit_request(i_lpc_ppi_if.low_power_exit_request),
    .clock_lane_stop_flag(i_lpc_ppi_if.clock_lane_stop_flag),
    .data_lane_stop_flag(i_lpc_ppi_if.data_lane_stop_flag),
    .clock_lane_low_power_active_n(i_lpc_ppi_if.clock_lane_low_power_active_n),
    .data_lane_low_power_active_n(i_lpc_ppi_if.data_lane_low_power_active_n),
    .data_lane_rx_low_power_flag(i_lpc_ppi_if.data_lane_rx_low_power_flag));

  task automatic chk(input logic [13:0] seen, input logic [13:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [13:0] w(logic cs, logic [3:0] ds, logic ca, logic [3:0] da, logic [3:0] df);
    return {cs, ds, ca, da, df};
  endfunction : w

  task automatic run(input int n);
    repeat (n) @(posedge i_clk);
  endtask : run

  task automatic set_lines(input logic [1:0] v);
    foreach (dl_line[i]) dl_line[i] <= v;
  endtask : set_lines

  // Any change without a pending note is a fault
  always @(posedge i_clk) begin
    if (i_rst_n && word !== prev_q) begin
      chk(word, (exp_q.size() > 0) ? exp_q.pop_front() : ~word, "status word");
    end
    prev_q <= word;
  end

  initial begin
    foreach (dl_line[i]) dl_line[i] = lpc_pkg::LP11;
    run(4);
    i_rst_n <= 1'b1;
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    cl_on <= 1'b1;
    run(10);
    chk(14'(cl_line), 14'(lpc_pkg::LP11), "clock line");
    exp_q.push_back(w(1'h0, 4'h0, 1'h1, 4'hF, 4'h0));
    fast <= 1'b1;
    run(10);
    chk(14'(hs_on), 14'h1, "hs clock on");
    cl_on <= 1'b0;
    for (int k = 0; k < 5 && i_lpc_ppi_if.clock_lane_on !== 1'b0; k++) @(posedge i_clk);
    if (i_lpc_ppi_if.clock_lane_on !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
    #1;
    chk(14'(cl_oe), 14'h0, "line oe off");
    chk(14'(hs_on), 14'h0, "hs clock off");
    // Requests while off must leave all status alone
    @(posedge i_clk);
    fast <= 1'b0;
    lp <= 1'b1;
    run(10);
    lp <= 1'b0;
    run(3);
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    cl_on <= 1'b1;
    run(10);
    exp_q.push_back(w(1'h0, 4'h0, 1'h0, 4'hF, 4'h0));
    lp <= 1'b1;
    run(10);
    chk(14'(cl_line), 14'(lpc_pkg::LP00), "ulps line");
    exp_q.push_back(w(1'h0, 4'h0, 1'h1, 4'hF, 4'h0));
    ex <= 1'b1;
    run(10);
    chk(14'(cl_line), 14'(lpc_pkg::LP10), "mark line");
    ex <= 1'b0;
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    lp <= 1'b0;
    run(10);
    chk(14'(cl_line), 14'(lpc_pkg::LP11), "stop line");
    // Exit held into Stop must be ignored there
    exp_q.push_back(w(1'h0, 4'h0, 1'h0, 4'hF, 4'h0));
    lp <= 1'b1;
    run(10);
    exp_q.push_back(w(1'h0, 4'h0, 1'h1, 4'hF, 4'h0));
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    ex <= 1'b1;
    run(1);
    lp <= 1'b0;
    run(10);
    ex <= 1'b0;
    run(5);
    $display("clock lane test done");
    m = 4'($random(seed));
    m = m | 4'h1;
    exp_q.push_back(w(1'h1, m, 1'h1, 4'hF, 4'h0));
    dl_on <= m;
    run(10);
    chk(14'(rx_on), 14'(m), "receivers on");
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, ~m, m));
    set_lines(lpc_pkg::LP00);
    run(10);
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, m));
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    set_lines(lpc_pkg::LP10);
    run(WAKE + 12);
    exp_q.push_back(w(1'h1, m, 1'h1, 4'hF, 4'h0));
    set_lines(lpc_pkg::LP11);
    run(10);
    exp_q.push_back(w(1'h1, 4'h0, 1'h1, 4'hF, 4'h0));
    dl_on <= 4'h0;
    run(10);
    exp_q.push_back(w(1'h0, 4'h0, 1'h1, 4'hF, 4'h0));
    cl_on <= 1'b0;
    run(10);
    chk(14'(exp_q.size()), 14'h0, "pending notes");
    $display("data lane test done");
    tally_and_finish();
  end
endmodule : tb_top
